// ### core/ccp_pwm_mode.sv
// Summary of operation
// RULE1: Period equals (limit plus one) times four oscillator periods times prescale.
// RULE2: Timer clears on the increment after it equals the limit.
// RULE3: Rollover sets the pin high unless duty is zero.
// RULE4: Rollover copies duty low byte and fraction into the active buffer.
// RULE5: Postscaler does not affect the PWM frequency.
// RULE6: Duty is ten bits: low byte on top, control bits 5:4 below.
// RULE7: High time equals duty times oscillator period times prescale.
// RULE8: Duty writes take effect only at the next period rollover.
// RULE9: Duty high byte is read-only while PWM mode is selected.
// RULE10: Active fraction bits live in a hidden latch, never readable.
// RULE11: Pin clears when active duty equals timer plus two sub bits.
// RULE12: Duty beyond the period never matches; pin stays high.
// RULE13: Software sets period, duty, pin, timer, then PWM mode.
// RULE14: Prescaler divides by 1, 4 or 16 from a 2-bit field.
// RULE15: Resolution is log2 of oscillator over PWM rate, at most ten.
// RULE16: Mode field upper bits both one selects PWM; zero disables.
// RULE17: Clearing control forces the output latch low.
// RULE18: Software must clear the direction bit so the pin drives.
// RULE19: Timer advances once per prescaled four-period instruction cycle.
// RULE20: A stopped timer holds its count and the pin level.
module ccp_pwm_mode (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ccp_pwm_pkg::ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [ccp_pwm_pkg::DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ccp_pwm_pkg::ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [ccp_pwm_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic [ccp_pwm_pkg::NUM_CH-1:0] pwm_output_pin,
	output logic [ccp_pwm_pkg::NUM_CH-1:0] pwm_output_pin_oe
);
	import ccp_pwm_pkg::*;

	// Bus slave state
	logic aw_got_r;
	logic aw_got_nxt;
	logic [ADDR_W-1:0] aw_addr_r;
	logic w_got_r;
	logic w_got_nxt;
	logic [7:0] w_byte_r;
	logic w_lane0_r;
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic bvalid_nxt;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic rvalid_nxt;
	logic [DATA_W-1:0] rdata_r;
	logic [1:0] rresp_r;

	// Block state
	logic [1:0] qphase_r;
	logic [7:0] cnt_r [NUM_TMR];
	logic [7:0] lim_r [NUM_TMR];
	logic [7:0] tctl_r [NUM_TMR];
	logic [3:0] pre_r [NUM_TMR];
	logic [7:0] dlo_r [NUM_CH];
	logic [7:0] ccon_r [NUM_CH];
	logic [NUM_CH-1:0] tsel_r;
	logic [NUM_CH-1:0] pindir_r;
	logic [NUM_CH-1:0] oe_r;

	// Per-timer and per-channel wires
	logic [NUM_TMR-1:0] t_run;
	logic [NUM_TMR-1:0] t_tick;
	logic [NUM_TMR-1:0] t_roll;
	logic [NUM_TMR-1:0] cnt_we;
	logic [NUM_TMR-1:0] lim_we;
	logic [NUM_TMR-1:0] tctl_we;
	logic [9:0] t_ext [NUM_TMR];
	logic [NUM_CH-1:0] dlo_we;
	logic [NUM_CH-1:0] dhi_we;
	logic [NUM_CH-1:0] ccon_we;
	logic [7:0] dhi [NUM_CH];
	logic [NUM_CH-1:0] pin;

	// Handshakes on the three request channels
	wire aw_hs = awvalid & awready_r;
	wire w_hs = wvalid & wready_r;
	wire ar_hs = arvalid & arready_r;
	wire do_write = aw_got_r & w_got_r & ~bvalid_r;
	wire wr_lane = do_write & w_lane0_r;

	// Write address hits for the shared registers
	wire tsel_we = wr_lane & (aw_addr_r == OFF_TSEL);
	wire pindir_we = wr_lane & (aw_addr_r == OFF_PINDIR);
	wire wr_hit_misc = (aw_addr_r == OFF_TSEL) | (aw_addr_r == OFF_PINDIR)
		| (aw_addr_r == OFF_PINSTAT);
	logic [NUM_TMR-1:0] wr_hit_tmr;
	logic [NUM_CH-1:0] wr_hit_ch;
	wire wr_hit = wr_hit_misc | (|wr_hit_tmr) | (|wr_hit_ch);

	// Next-state terms of the bus slave
	assign aw_got_nxt = (aw_got_r | aw_hs) & ~do_write;
	assign w_got_nxt = (w_got_r | w_hs) & ~do_write;
	assign bvalid_nxt = do_write | (bvalid_r & ~bready);
	assign rvalid_nxt = ar_hs | (rvalid_r & ~rready);

	// Write address and data capture, in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_addr_r <= '0;
			w_byte_r <= RST_BYTE;
			w_lane0_r <= 1'b0;
		end else begin
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			if (aw_hs) begin
				aw_addr_r <= awaddr;
			end
			if (w_hs) begin
				w_byte_r <= wdata[7:0];
				w_lane0_r <= wstrb[0];
			end
		end
	end

	// Write response and ready flags
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else begin
			awready_r <= ~aw_got_nxt & ~bvalid_nxt;
			wready_r <= ~w_got_nxt & ~bvalid_nxt;
			bvalid_r <= bvalid_nxt;
			if (do_write) begin
				bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// Read data path
	logic [7:0] rd_byte;
	logic rd_hit;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
		end else begin
			arready_r <= ~rvalid_nxt;
			rvalid_r <= rvalid_nxt;
			if (ar_hs) begin
				rdata_r <= {{(DATA_W-8){1'b0}}, rd_byte};
				rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// Read selection; the hidden fraction latch has no address
	// RULE10 latch not readable
	assign rd_byte = (araddr == OFF_CNT[0]) ? cnt_r[0]
		: (araddr == OFF_LIM[0]) ? lim_r[0]
		: (araddr == OFF_TCTL[0]) ? (tctl_r[0] & TCTL_MASK)
		: (araddr == OFF_CNT[1]) ? cnt_r[1]
		: (araddr == OFF_LIM[1]) ? lim_r[1]
		: (araddr == OFF_TCTL[1]) ? (tctl_r[1] & TCTL_MASK)
		: (araddr == OFF_DLO[0]) ? dlo_r[0]
		: (araddr == OFF_DHI[0]) ? dhi[0]
		: (araddr == OFF_DLO[1]) ? dlo_r[1]
		: (araddr == OFF_DHI[1]) ? dhi[1]
		: (araddr == OFF_CCON[0]) ? (ccon_r[0] & CCON_MASK)
		: (araddr == OFF_CCON[1]) ? (ccon_r[1] & CCON_MASK)
		: (araddr == OFF_TSEL) ? {6'h00, tsel_r}
		: (araddr == OFF_PINDIR) ? {6'h00, pindir_r}
		: (araddr == OFF_PINSTAT) ? {6'h00, pin}
		: RST_BYTE;
	assign rd_hit = (araddr == OFF_CNT[0]) | (araddr == OFF_LIM[0])
		| (araddr == OFF_TCTL[0]) | (araddr == OFF_CNT[1])
		| (araddr == OFF_LIM[1]) | (araddr == OFF_TCTL[1])
		| (araddr == OFF_DLO[0]) | (araddr == OFF_DHI[0])
		| (araddr == OFF_DLO[1]) | (araddr == OFF_DHI[1])
		| (araddr == OFF_CCON[0]) | (araddr == OFF_CCON[1])
		| (araddr == OFF_TSEL) | (araddr == OFF_PINDIR)
		| (araddr == OFF_PINSTAT);

	// Quarter-cycle phase: four oscillator periods per instruction cycle
	// RULE19 instruction cycle phase
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			qphase_r <= '0;
		end else begin
			qphase_r <= qphase_r + 2'h1;
		end
	end

	// Two period timers with prescaler and extended count
	for (genvar t = 0; t < NUM_TMR; t++) begin : g_tmr
		wire [1:0] ps = tctl_r[t][TCTL_PS_LSB +: 2];
		// RULE14 prescale select
		wire [3:0] pre_last = (ps == PS_DIV1) ? PRE_ZERO
			: (ps == PS_DIV4) ? PS4_LAST : PS16_LAST;
		wire q_end = (qphase_r == QCYC_LAST);
		wire [3:0] pre_nxt = (t_run[t] & q_end)
			? ((pre_r[t] >= pre_last) ? PRE_ZERO : pre_r[t] + 4'h1) : pre_r[t];
		wire [7:0] cnt_nxt = cnt_we[t] ? w_byte_r : t_roll[t] ? RST_BYTE
			: t_tick[t] ? cnt_r[t] + 8'h01 : cnt_r[t];
		// RULE11 sub-count bits of the next cycle, so the pin falls on time
		wire [1:0] sub_nxt = (ps == PS_DIV1) ? qphase_r + 2'h1
			: (ps == PS_DIV4) ? pre_nxt[1:0] : pre_nxt[3:2];

		assign t_run[t] = tctl_r[t][TCTL_RUN_BIT];
		// RULE1 prescaled increment
		assign t_tick[t] = t_run[t] & q_end & (pre_r[t] == pre_last);
		// RULE2 limit match
		assign t_roll[t] = t_tick[t] & (cnt_r[t] == lim_r[t]);
		// RULE15 ten-bit time base
		assign t_ext[t] = {cnt_nxt, sub_nxt};
		assign cnt_we[t] = wr_lane & (aw_addr_r == OFF_CNT[t]);
		assign lim_we[t] = wr_lane & (aw_addr_r == OFF_LIM[t]);
		assign tctl_we[t] = wr_lane & (aw_addr_r == OFF_TCTL[t]);
		assign wr_hit_tmr[t] = (aw_addr_r == OFF_CNT[t]) | (aw_addr_r == OFF_LIM[t])
			| (aw_addr_r == OFF_TCTL[t]);

		// Count, limit and control; postscale bits are stored only
		// RULE5 postscale unused
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				cnt_r[t] <= RST_BYTE;
				lim_r[t] <= RST_BYTE;
				tctl_r[t] <= RST_BYTE;
				pre_r[t] <= PRE_ZERO;
			end else begin
				if (lim_we[t]) begin
					lim_r[t] <= w_byte_r;
				end
				if (tctl_we[t]) begin
					tctl_r[t] <= w_byte_r & TCTL_MASK;
				end
				// RULE20 stopped timer holds
				if (cnt_we[t]) begin
					cnt_r[t] <= w_byte_r;
				end else if (t_roll[t]) begin
					cnt_r[t] <= RST_BYTE;
				end else if (t_tick[t]) begin
					cnt_r[t] <= cnt_r[t] + 8'h01;
				end
				pre_r[t] <= pre_nxt;
			end
		end

		AST_ROLL_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
			t_roll[t] && !cnt_we[t] |=> cnt_r[t] == RST_BYTE)
			else $error("timer not cleared after limit match");
		AST_STOP_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // RULE20
			!t_run[t] && !cnt_we[t] && !tctl_we[t] |=> $stable(cnt_r[t]) && !t_roll[t])
			else $error("stopped timer moved");
		AST_TICK_SPACING: assert property (@(posedge aclk) disable iff (!aresetn) // RULE19
			t_tick[t] && !tctl_we[t] |=> !t_tick[t] [*3])
			else $error("timer advanced faster than instruction rate");
		COV_ROLL: cover property (@(posedge aclk) disable iff (!aresetn)
			t_roll[t]);
	end

	// Channel duty and control registers
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		wire [3:0] mode = ccon_r[c][CCON_MODE_LSB +: 4];
		wire pwm_sel = (mode[3:2] == MODE_PWM_TOP);
		wire tmr = tsel_r[c];

		assign dlo_we[c] = wr_lane & (aw_addr_r == OFF_DLO[c]);
		// RULE9 high byte read-only
		assign dhi_we[c] = wr_lane & (aw_addr_r == OFF_DHI[c]) & ~pwm_sel;
		assign ccon_we[c] = wr_lane & (aw_addr_r == OFF_CCON[c]);
		assign wr_hit_ch[c] = (aw_addr_r == OFF_DLO[c]) | (aw_addr_r == OFF_DHI[c])
			| (aw_addr_r == OFF_CCON[c]);

		// Duty writes land at any time; the channel buffers them
		// RULE8 deferred duty
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				dlo_r[c] <= RST_BYTE;
				ccon_r[c] <= RST_BYTE;
			end else begin
				if (dlo_we[c]) begin
					dlo_r[c] <= w_byte_r;
				end
				if (ccon_we[c]) begin
					ccon_r[c] <= w_byte_r & CCON_MASK;
				end
			end
		end

		// RULE7 duty against prescaled base
		// RULE12 no match keeps pin high
		pwm_duty_channel u_chan (
			.aclk(aclk),
			.aresetn(aresetn),
			.mode(mode),
			.duty_low(dlo_r[c]),
			.duty_frac(ccon_r[c][CCON_FRAC_LSB +: 2]),
			.rollover(t_roll[tmr]),
			.live(t_run[tmr]),
			.ext_count(t_ext[tmr]),
			.dh_we(dhi_we[c]),
			.dh_wdata(w_byte_r),
			.duty_high(dhi[c]),
			.pin(pin[c])
		);
	end

	// Timer routing and pin direction
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tsel_r <= '0;
			pindir_r <= RST_PINDIR;
			oe_r <= '0;
		end else begin
			if (tsel_we) begin
				tsel_r <= w_byte_r[NUM_CH-1:0];
			end
			if (pindir_we) begin
				pindir_r <= w_byte_r[NUM_CH-1:0];
			end
			// RULE18 direction gates drive
			oe_r <= ~pindir_r;
		end
	end

	// Outputs, all from flip-flops
	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	assign pwm_output_pin = pin;
	assign pwm_output_pin_oe = oe_r;

	AST_B_AFTER_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
		aw_got_r && w_got_r && !bvalid_r |=> bvalid_r)
		else $error("write response missing");
	AST_R_AFTER_ADDR: assert property (@(posedge aclk) disable iff (!aresetn)
		ar_hs |=> rvalid_r && !arready_r)
		else $error("read data missing");
	COV_WRITE: cover property (@(posedge aclk) disable iff (!aresetn)
		bvalid_r && bready);
	COV_READ: cover property (@(posedge aclk) disable iff (!aresetn)
		rvalid_r && rready);
endmodule : ccp_pwm_mode

// ### core/ccp_pwm_pkg.sv
package ccp_pwm_pkg;
	// Bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_TMR = 2;
	localparam int NUM_CH = 2;

	// Register byte addresses
	localparam logic [7:0] OFF_CNT [NUM_TMR] = '{8'h00, 8'h0c};
	localparam logic [7:0] OFF_LIM [NUM_TMR] = '{8'h04, 8'h10};
	localparam logic [7:0] OFF_TCTL [NUM_TMR] = '{8'h08, 8'h14};
	localparam logic [7:0] OFF_DLO [NUM_CH] = '{8'h18, 8'h20};
	localparam logic [7:0] OFF_DHI [NUM_CH] = '{8'h1c, 8'h24};
	localparam logic [7:0] OFF_CCON [NUM_CH] = '{8'h28, 8'h2c};
	localparam logic [7:0] OFF_TSEL = 8'h30;
	localparam logic [7:0] OFF_PINDIR = 8'h34;
	localparam logic [7:0] OFF_PINSTAT = 8'h38;

	// Timer control fields
	localparam int TCTL_PS_LSB = 0;
	localparam int TCTL_RUN_BIT = 2;
	localparam int TCTL_POST_LSB = 3;
	localparam logic [7:0] TCTL_MASK = 8'h7f;

	// Channel control fields
	localparam int CCON_MODE_LSB = 0;
	localparam int CCON_FRAC_LSB = 4;
	localparam logic [7:0] CCON_MASK = 8'h3f;
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [1:0] MODE_PWM_TOP = 2'h3;

	// Prescaler and quarter-cycle encodings
	localparam logic [1:0] PS_DIV1 = 2'h0;
	localparam logic [1:0] PS_DIV4 = 2'h1;
	localparam logic [1:0] QCYC_LAST = 2'h3;
	localparam logic [3:0] PRE_ZERO = 4'h0;
	localparam logic [3:0] PS4_LAST = 4'h3;
	localparam logic [3:0] PS16_LAST = 4'hf;

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] RST_PINDIR = 2'h3;

	// Write/read responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ccp_pwm_pkg

// ### core/pwm_duty_channel.sv
module pwm_duty_channel (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] mode,
	input wire logic [7:0] duty_low,
	input wire logic [1:0] duty_frac,
	input wire logic rollover,
	input wire logic live,
	input wire logic [9:0] ext_count,
	input wire logic dh_we,
	input wire logic [7:0] dh_wdata,
	output logic [7:0] duty_high,
	output logic pin
);
	import ccp_pwm_pkg::*;

	logic [1:0] frac_latch_r;
	logic [7:0] duty_high_r;
	logic pin_r;

	// Mode decode and duty compare
	// RULE16 mode decode
	wire pwm_on = (mode[3:2] == MODE_PWM_TOP);
	wire chan_off = (mode == MODE_OFF);
	// RULE6 ten-bit duty
	wire [9:0] duty_next = {duty_low, duty_frac};
	wire [9:0] duty_active = {duty_high_r, frac_latch_r};
	// RULE11 duty match
	wire duty_match = live & (duty_active == ext_count);

	// Double buffer and output latch
	// RULE17 off clears latch
	always_ff @(posedge aclk) begin
		if (!aresetn || chan_off) begin
			duty_high_r <= RST_BYTE;
			frac_latch_r <= '0;
			pin_r <= 1'b0;
		end else if (pwm_on) begin
			// RULE4 reload at rollover
			if (rollover) begin
				duty_high_r <= duty_low;
				frac_latch_r <= duty_frac;
				// RULE3 set unless zero
				pin_r <= (duty_next != '0);
			end else if (duty_match) begin
				pin_r <= 1'b0;
			end
		end else if (dh_we) begin
			duty_high_r <= dh_wdata;
		end
	end

	assign duty_high = duty_high_r;
	assign pin = pin_r;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_PIN_SET: assert property ( // RULE3
		pwm_on && rollover && duty_next != '0 |=> pin_r)
		else $error("pin not set at rollover");
	AST_ZERO_LOW: assert property ( // RULE3
		pwm_on && rollover && duty_next == '0 |=> !pin_r)
		else $error("pin set with zero duty");
	AST_RELOAD: assert property ( // RULE4
		pwm_on && rollover |=> duty_active == $past(duty_next))
		else $error("duty not reloaded at rollover");
	AST_HOLD_DUTY: assert property ( // RULE8
		pwm_on && !rollover && !chan_off |=> $stable(duty_active))
		else $error("active duty changed mid-period");
	AST_MATCH_CLEAR: assert property ( // RULE11
		pwm_on && !rollover && duty_match |=> !pin_r)
		else $error("pin not cleared on duty match");
	AST_OFF_LOW: assert property ( // RULE17
		chan_off |=> !pin_r && duty_high_r == RST_BYTE)
		else $error("off mode did not clear output");
	COV_PIN_RISE: cover property (pwm_on && !pin_r ##1 pin_r);
	COV_PIN_FALL: cover property (pwm_on && pin_r ##1 !pin_r);
endmodule : pwm_duty_channel

// ### tb/ccp_pwm_mode_tb.sv
module ccp_pwm_mode_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ccp_pwm_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h0;
	logic [7:0] araddr = 8'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h1;
	logic [2:0] prot = 3'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, pin, pin_oe;
	logic [31:0] rdata;
	logic [15:0] high_len, period_len, rd, resp, cnt;
	logic [15:0] high_len_b, period_len_b;
	int bad_count = 0;
	int n_checks = 0;
	int k;
	logic [7:0] ctl [3] = '{8'h04, 8'h7d, 8'h06};
	int ps [3] = '{1, 4, 16};

	// Clock at 100 MHz
	always #5 aclk = ~aclk;

	ccp_pwm_mode i_ccp_pwm_mode (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awprot(prot), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(prot), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.pwm_output_pin(pin), .pwm_output_pin_oe(pin_oe));

	pwm_load_model i_pwm_load_model (.aclk(aclk), .pin(pin[0]), .oe(pin_oe[0]),
		.high_len(high_len), .period_len(period_len));

	// Second load, on channel five
	pwm_load_model i_pwm_load_model_b (.aclk(aclk), .pin(pin[1]), .oe(pin_oe[1]),
		.high_len(high_len_b), .period_len(period_len_b));

	task automatic conclude();
		if (bad_count == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			bad_count++;
		end
	endtask : chk

	task automatic timeout();
		bad_count++;
		$display("[ERR] bus_response expected 1 seen 0");
		conclude();
	endtask : timeout

	// Bus write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int i;
		logic aw_done;
		logic w_done;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw_done = 1'b0;
		w_done = 1'b0;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (!aw_done && awready) begin
				awvalid <= 1'b0;
				aw_done = 1'b1;
			end
			if (!w_done && wready) begin
				wvalid <= 1'b0;
				w_done = 1'b1;
			end
			if (bvalid) break;
		end
		bready <= 1'b0;
		resp = {14'h0, bresp};
		if (i == 50) timeout();
	endtask : wr

	// Bus read: result lands in rd and resp
	task automatic rdr(input logic [7:0] a);
		int i;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		rd = rdata[15:0];
		resp = {14'h0, rresp};
		if (i == 50) timeout();
	endtask : rdr

	task automatic rchk(input string what, input logic [7:0] a, input logic [15:0] exp);
		rdr(a);
		chk(what, exp, rd);
	endtask : rchk

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc

	// Counts cycles where the pin differs from the expected level
	task automatic hold(input logic v, input int n, input string what);
		int c;
		c = 0;
		repeat (n) begin
			@(posedge aclk);
			if (pin[0] !== v) c++;
		end
		chk(what, 16'h0, c[15:0]);
	endtask : hold

	// Main sequence
	initial begin
		cyc(4);
		aresetn <= 1'b1;
		rchk("limit_a", OFF_LIM[0], 16'h0);
		rchk("pin_dir", OFF_PINDIR, 16'h3);
		rchk("ctrl4", OFF_CCON[0], 16'h0);
		rdr(8'h3c);
		chk("rresp_unmapped", 16'h2, resp);
		wr(8'h3c, 8'h55);
		chk("bresp_unmapped", 16'h2, resp);
		chk("oe_off", 16'h0, {15'h0, pin_oe[0]});
		// Period, duty, pin, timer, then mode: duty 22, period 40 clocks
		wr(OFF_LIM[0], 8'h09);
		wr(OFF_DLO[0], 8'h05);
		wr(OFF_PINDIR, 8'h02);
		wr(OFF_TCTL[0], 8'h04);
		wr(OFF_CCON[0], 8'h2c);
		cyc(4);
		chk("oe_on", 16'h1, {15'h0, pin_oe[0]});
		// Each prescale factor, postscaler set on the middle one
		for (k = 0; k < 3; k++) begin
			wr(OFF_TCTL[0], ctl[k]);
			cyc(120 * ps[k] + 10);
			chk("period", 16'(40 * ps[k]), period_len);
			chk("high", 16'(22 * ps[k]), high_len);
		end
		rchk("duty_hi", OFF_DHI[0], 16'h05);
		wr(OFF_DHI[0], 8'haa);
		chk("bresp_dhi", 16'h0, resp);
		rchk("duty_hi_ro", OFF_DHI[0], 16'h05);
		// Stopped timer: count, active duty and pin all hold
		wr(OFF_TCTL[0], 8'h00);
		rdr(OFF_CNT[0]);
		cnt = rd;
		wr(OFF_DLO[0], 8'h07);
		hold(pin[0], 100, "pin_hold");
		rchk("count_hold", OFF_CNT[0], cnt);
		rchk("duty_hold", OFF_DHI[0], 16'h05);
		wr(OFF_TCTL[0], 8'h04);
		cyc(130);
		rchk("duty_new", OFF_DHI[0], 16'h07);
		chk("high_new", 16'd30, high_len);
		// Duty 46 beyond a 40 clock period
		wr(OFF_DLO[0], 8'h0b);
		cyc(90);
		hold(1'b1, 100, "pin_full");
		wr(OFF_CCON[0], 8'h00);
		cyc(2);
		hold(1'b0, 50, "pin_cleared");
		rchk("duty_cleared", OFF_DHI[0], 16'h0);
		// Zero duty never raises the pin
		wr(OFF_DLO[0], 8'h00);
		wr(OFF_CCON[0], 8'h0c);
		hold(1'b0, 200, "pin_zero");
		// Channel five on timer b: period 80, duty 13 at prescale 4
		wr(OFF_LIM[1], 8'h04);
		wr(OFF_DLO[1], 8'h03);
		wr(OFF_PINDIR, 8'h00);
		wr(OFF_TSEL, 8'h02);
		wr(OFF_TCTL[1], 8'h05);
		wr(OFF_CCON[1], 8'h1c);
		cyc(250);
		chk("period_b", 16'h50, period_len_b);
		chk("high_b", 16'h34, high_len_b);
		chk("oe_b", 16'h3, {14'h0, pin_oe});
		// Outside PWM mode, with the channel not off, the high byte takes writes
		wr(OFF_CCON[0], 8'h04);
		wr(OFF_DHI[0], 8'haa);
		rchk("duty_hi_rw", OFF_DHI[0], 16'haa);
		conclude();
	end
endmodule : ccp_pwm_mode_tb

// ### tb/pwm_load_model.sv
// Load on one PWM pin: measures pulse width and pulse spacing in clocks
module pwm_load_model (
	input wire logic aclk,
	input wire logic pin,
	input wire logic oe,
	output logic [15:0] high_len,
	output logic [15:0] period_len
);
	timeunit 1ns;
	timeprecision 1ps;
	logic prev_r = 1'b0;
	logic [15:0] t_r = 16'h0;
	logic drive;

	// Only a driven pin counts as a level seen by the load
	assign drive = oe & pin;

	// Rise restarts the interval count, fall records the high time
	always_ff @(posedge aclk) begin
		prev_r <= drive;
		t_r <= t_r + 16'h1;
		if (drive && !prev_r) begin
			period_len <= t_r;
			t_r <= 16'h1;
		end
		if (prev_r && !drive) begin
			high_len <= t_r;
		end
	end
endmodule : pwm_load_model
